//--- slsel_pkg.sv
// Constants, field layout and carrier types for the lane select register.
// Assumes a management front end that already decoded the serial frame.
package slsel_pkg;

  // ----------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------
  localparam logic [4:0]  DEV_ADDR     = 5'h1e;
  localparam logic [15:0] CFG_ADDR     = 16'h0006;
  localparam logic [15:0] CTRL_B_ADDR  = 16'h0007;
  localparam logic [15:0] CTRL_C_ADDR  = 16'h0008;
  localparam logic [15:0] CHAN_ADDR    = 16'h000c;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int          LANE_CNT     = 4;
  localparam int          MASK_LSB     = 12;
  localparam int          RSV_LSB      = 10;
  localparam int          BW_LSB       = 8;
  localparam logic [15:0] CFG_RST      = 16'hf115;
  localparam logic [15:0] CTRL_B_RST   = 16'hdc04;
  localparam logic [15:0] CTRL_C_RST   = 16'h0000;
  localparam logic [15:0] CHAN_RST     = 16'h0000;
  localparam logic [15:0] RD_NONE      = 16'h0000;

  // One-hot read selections
  localparam logic [3:0]  SEL_LANE0    = 4'h1;
  localparam logic [3:0]  SEL_LANE1    = 4'h2;
  localparam logic [3:0]  SEL_LANE2    = 4'h4;
  localparam logic [3:0]  SEL_LANE3    = 4'h8;

  // Which steered register a lane write targets
  typedef enum logic [1:0]
  {
    STR_CTRL_B = 2'b00,
    STR_CTRL_C = 2'b01,
    STR_CHAN   = 2'b10,
    STR_NONE   = 2'b11
  } slsel_steer_t;

  typedef struct packed
  {
    logic        valid;
    logic        write;
    logic [4:0]  dev;
    logic [15:0] addr;
    logic [15:0] wdata;
  } slsel_req_t;

  typedef struct packed
  {
    logic        valid;
    logic [15:0] rdata;
  } slsel_rsp_t;

  typedef struct packed
  {
    logic [15:0] ctrl_b;
    logic [15:0] ctrl_c;
    logic [15:0] chan;
  } slsel_lane_cfg_t;

endpackage

//--- slsel_lane.sv
// One lane's copy of the three steered configuration registers.
// Assumes an asynchronous active-low reset and a one-cycle write strobe.
`timescale 1ns/1ps
`default_nettype none

module slsel_lane
(
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  input  wire logic                        wr_en,
  input  wire slsel_pkg::slsel_steer_t     wr_sel,
  input  wire logic [15:0]                 wr_data,
  output var  slsel_pkg::slsel_lane_cfg_t  cfg_r
);
  import slsel_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_r.ctrl_b <= CTRL_B_RST;
      cfg_r.ctrl_c <= CTRL_C_RST;
      cfg_r.chan   <= CHAN_RST;
    end
    else if (wr_en)
    begin
      case (wr_sel)
        STR_CTRL_B: cfg_r.ctrl_b <= wr_data;
        STR_CTRL_C: cfg_r.ctrl_c <= wr_data;
        STR_CHAN:   cfg_r.chan   <= wr_data;
        default:    cfg_r.chan   <= cfg_r.chan;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- slsel_top.sv
// Lane select and low-side PLL bandwidth register with steered lane banks.
// Assumes decoded management requests on core_clk, one per cycle at most.
`timescale 1ns/1ps
`default_nettype none

module slsel_top
(
  input  wire logic                        core_clk,
  input  wire logic                        resetn,
  input  wire slsel_pkg::slsel_req_t       mgmt_req,
  output var  slsel_pkg::slsel_rsp_t       mgmt_rsp_r,
  output var  logic [3:0]                  lane_config_mask,
  output var  logic [1:0]                  low_side_pll_loop_bw,
  output var  slsel_pkg::slsel_lane_cfg_t  lane_cfg [slsel_pkg::LANE_CNT]
);
  import slsel_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0]   rst_pipe_r;
  logic         rst_n;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rst_pipe_r <= 2'b00;
    else
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
  end

  assign rst_n = rst_pipe_r[1];

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic         dev_hit;
  logic         cfg_hit;
  logic         cfg_wr;
  logic         steer_wr;
  slsel_steer_t steer_sel;
  logic [15:0]  cfg_r;
  logic [3:0]   mask;
  logic [15:0]  rd_nxt;

  assign dev_hit = mgmt_req.valid && (mgmt_req.dev == DEV_ADDR);
  assign cfg_hit = dev_hit && (mgmt_req.addr == CFG_ADDR);
  assign cfg_wr  = cfg_hit && mgmt_req.write;
  assign mask    = cfg_r[MASK_LSB +: LANE_CNT];

  always_comb
  begin
    steer_sel = STR_NONE;
    if (dev_hit)
    begin
      case (mgmt_req.addr)
        CTRL_B_ADDR: steer_sel = STR_CTRL_B;
        CTRL_C_ADDR: steer_sel = STR_CTRL_C;
        CHAN_ADDR:   steer_sel = STR_CHAN;
        default:     steer_sel = STR_NONE;
      endcase
    end
  end

  assign steer_wr = mgmt_req.write && (steer_sel != STR_NONE);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Whole word is stored; the reserved pair and bandwidth code are
  // kept as written, so illegal codes are the writer's problem.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_r <= CFG_RST;
    else if (cfg_wr)
      cfg_r <= mgmt_req.wdata;
  end

  assign lane_config_mask     = cfg_r[MASK_LSB +: LANE_CNT];
  assign low_side_pll_loop_bw = cfg_r[BW_LSB +: 2];

  // ----------------------------------------------------------------
  // Lane banks
  // ----------------------------------------------------------------
  for (genvar i = 0; i < LANE_CNT; i++)
  begin : g_lane
    slsel_lane u_lane
    (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .wr_en    (steer_wr && mask[i]),
      .wr_sel   (steer_sel),
      .wr_data  (mgmt_req.wdata),
      .cfg_r    (lane_cfg[i])
    );
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  function automatic logic [15:0] pick(slsel_lane_cfg_t c, slsel_steer_t s);
    case (s)
      STR_CTRL_B: pick = c.ctrl_b;
      STR_CTRL_C: pick = c.ctrl_c;
      STR_CHAN:   pick = c.chan;
      default:    pick = RD_NONE;
    endcase
  endfunction

  always_comb
  begin
    rd_nxt = RD_NONE;
    if (cfg_hit)
      rd_nxt = cfg_r;
    else
    begin
      case (mask)
        SEL_LANE0: rd_nxt = pick(lane_cfg[0], steer_sel);
        SEL_LANE1: rd_nxt = pick(lane_cfg[1], steer_sel);
        SEL_LANE2: rd_nxt = pick(lane_cfg[2], steer_sel);
        SEL_LANE3: rd_nxt = pick(lane_cfg[3], steer_sel);
        default:   rd_nxt = RD_NONE;
      endcase
    end
  end

  // Answer one cycle after every request; writes answer with zero
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      mgmt_rsp_r <= '0;
    else
    begin
      mgmt_rsp_r.valid <= mgmt_req.valid;
      mgmt_rsp_r.rdata <= mgmt_req.write ? RD_NONE : rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_steer_wr_b;
    mgmt_req.valid && mgmt_req.write && mgmt_req.dev == DEV_ADDR &&
    mgmt_req.addr == CTRL_B_ADDR;
  endsequence

  sequence s_steer_rd(logic [15:0] a, logic [3:0] m);
    mgmt_req.valid && !mgmt_req.write && mgmt_req.dev == DEV_ADDR &&
    mgmt_req.addr == a && mask == m;
  endsequence

  a_mask_write: assert property (
    cfg_wr |=> lane_config_mask == $past(mgmt_req.wdata[15:12]))
    else $error("lane mask not taken from write");

  a_lane_keep: assert property (
    s_steer_wr_b ##0 !mask[0] |=> $stable(lane_cfg[0]))
    else $error("unselected lane changed");

  a_lane_update: assert property (
    s_steer_wr_b ##0 mask[1] |=>
      lane_cfg[1].ctrl_b == $past(mgmt_req.wdata))
    else $error("selected lane not written");

  a_multi_lane: assert property (
    s_steer_wr_b ##0 mask == 4'h3 |=>
      lane_cfg[0].ctrl_b == lane_cfg[1].ctrl_b &&
      lane_cfg[1].ctrl_b == $past(mgmt_req.wdata))
    else $error("multi lane write not applied to both");

  a_read_lane2: assert property (
    s_steer_rd(CTRL_B_ADDR, SEL_LANE2) |=>
      mgmt_rsp_r.valid && mgmt_rsp_r.rdata == lane_cfg[2].ctrl_b)
    else $error("lane 2 read wrong");

  a_read_lane3: assert property (
    s_steer_rd(CTRL_C_ADDR, SEL_LANE3) |=>
      mgmt_rsp_r.rdata == lane_cfg[3].ctrl_c)
    else $error("lane 3 read wrong");

  a_bw_field: assert property (
    cfg_wr |=> low_side_pll_loop_bw == $past(mgmt_req.wdata[9:8]))
    else $error("bandwidth code not taken");

  a_rsv_rw: assert property (
    cfg_wr |=> cfg_r[11:10] == $past(mgmt_req.wdata[11:10]))
    else $error("reserved pair not stored");

  a_reset_value: assert property (
    $rose(rst_n) |-> cfg_r == CFG_RST && lane_config_mask == 4'hf)
    else $error("register reset value wrong");

  a_mask_hold: assert property (
    !cfg_wr |=> $stable(lane_config_mask))
    else $error("mask changed without a write");

endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the lane select and PLL bandwidth register.
// Assumes slsel_pkg and slsel_top are compiled ahead of this file.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end

module tb_top;
  import slsel_pkg::*;

  logic            core_clk;
  logic            resetn;
  slsel_req_t      mgmt_req;
  slsel_rsp_t      mgmt_rsp_r;
  logic [3:0]      lane_config_mask;
  logic [1:0]      low_side_pll_loop_bw;
  slsel_lane_cfg_t lane_cfg [LANE_CNT];
  int              failures;
  int              checked;
  logic [15:0]     v;

  slsel_top u_dut
  (
    .core_clk             (core_clk),
    .resetn               (resetn),
    .mgmt_req             (mgmt_req),
    .mgmt_rsp_r           (mgmt_rsp_r),
    .lane_config_mask     (lane_config_mask),
    .low_side_pll_loop_bw (low_side_pll_loop_bw),
    .lane_cfg             (lane_cfg)
  );

  // ----------------------------------------------------------------
  // Clock, closing and watchdog
  // ----------------------------------------------------------------
  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  task automatic end_sim();
    if (failures == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Whole sequence is well under 200 cycles; 5000 leaves ample margin
  initial
  begin
    #20000;
    failures++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  // Request rides one cycle; the answer is read in the cycle after
  task automatic acc(input logic w, input logic [4:0] d,
                     input logic [15:0] a, input logic [15:0] wd,
                     output logic [15:0] rd);
    @(posedge core_clk);
    mgmt_req <= '{valid: 1'b1, write: w, dev: d, addr: a, wdata: wd};
    @(posedge core_clk);
    mgmt_req.valid <= 1'b0;
    #1;
    `CHK("rsp_valid", 1'b1, mgmt_rsp_r.valid)
    rd = mgmt_rsp_r.rdata;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] t;
    acc(1'b1, DEV_ADDR, a, d, t);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] t;
    acc(1'b0, DEV_ADDR, a, 16'h0000, t);
    `CHK("rdata", e, t)
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    failures = 0;
    checked  = 0;
    resetn   = 1'b0;
    mgmt_req = '0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("mask", 4'hf, lane_config_mask)
    `CHK("bw", 2'b01, low_side_pll_loop_bw)
    rd_chk(CFG_ADDR, 16'hf115);
    // Mask 0011 steers one write into lanes 0 and 1 together
    wr(CFG_ADDR, 16'h3115);
    `CHK("mask", 4'h3, lane_config_mask)
    wr(CTRL_B_ADDR, 16'h1234);
    for (int i = 0; i < LANE_CNT; i++)
    begin
      v = (i < 2) ? 16'h1234 : CTRL_B_RST;
      `CHK("ctrl_b", v, lane_cfg[i].ctrl_b)
    end
    // Distinct values per lane under one-hot masks
    for (int i = 0; i < LANE_CNT; i++)
    begin
      wr(CFG_ADDR, {4'(1 << i), 12'h115});
      wr(CTRL_C_ADDR, 16'h0c00 + 16'(i));
      wr(CHAN_ADDR, 16'h00a0 + 16'(i));
    end
    for (int i = 0; i < LANE_CNT; i++)
    begin
      `CHK("ctrl_c", 16'h0c00 + 16'(i), lane_cfg[i].ctrl_c)
      `CHK("chan", 16'h00a0 + 16'(i), lane_cfg[i].chan)
    end
    // Reads select one lane each, lane 3 included
    for (int i = 0; i < LANE_CNT; i++)
    begin
      wr(CFG_ADDR, {4'(1 << i), 12'h115});
      rd_chk(CTRL_B_ADDR, (i < 2) ? 16'h1234 : CTRL_B_RST);
      rd_chk(CTRL_C_ADDR, 16'h0c00 + 16'(i));
      rd_chk(CHAN_ADDR, 16'h00a0 + 16'(i));
    end
    // Multi-hot mask: reads carry no meaning, zero by choice
    wr(CFG_ADDR, 16'h6115);
    rd_chk(CTRL_B_ADDR, RD_NONE);
    // Reserved bits and bandwidth code 10 store as written
    // Only the legal bandwidth codes 01 and 10 are written to this device; code 00 goes only to device 1f
    wr(CFG_ADDR, 16'h1e2a);
    #1;
    `CHK("bw", 2'b10, low_side_pll_loop_bw)
    rd_chk(CFG_ADDR, 16'h1e2a);
    // Wrong device address must not touch the register
    acc(1'b1, 5'h1f, CFG_ADDR, 16'h0000, v);
    `CHK("rdata", 16'h0000, v)
    rd_chk(CFG_ADDR, 16'h1e2a);
    // A read under a foreign device address must not return the register
    acc(1'b0, 5'h1f, CFG_ADDR, 16'h0000, v);
    `CHK("rdata", 16'h0000, v)
    rd_chk(16'h0009, 16'h0000);
    `CHK("mask", 4'h1, lane_config_mask)
    end_sim();
  end

endmodule

`default_nettype wire
